// [rtl/rtc_map.svh]
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RTC_OFS_CTRL      8'h00
`define RTC_OFS_ACT_THR   8'h04
`define RTC_OFS_DEACT_THR 8'h08
`define RTC_OFS_ACT_DLY   8'h0C
`define RTC_OFS_DEACT_DLY 8'h10
`define RTC_OFS_MAX_RUN   8'h14
`define RTC_OFS_ALM_EN    8'h18
`define RTC_OFS_ALM_LVL   8'h1C
`define RTC_OFS_SCHED     8'h20
`define RTC_OFS_STATUS    8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTC_CTRL_PROF_LSB 0
`define RTC_CTRL_DIR_BIT  4
`define RTC_CTRL_COMB_BIT 5
`define RTC_CTRL_OP_LSB   8
`define RTC_SCHED_QUIET   0
`define RTC_SCHED_EXER    1
`define RTC_STAT_RELAY    0
`define RTC_STAT_FSM_LSB  1
`define RTC_STAT_ERR      3
`define RTC_STAT_ACT      4
`define RTC_STAT_DEACT    5
`define RTC_STAT_OP_LSB   8

// ----------------------------------------------------------------------------
// Reset values and threshold limits
// ----------------------------------------------------------------------------
`define RTC_RST_THR       16'h0000
`define RTC_RST_DLY       32'h0000_0000
`define RTC_RST_ALM       32'h0000_0000
`define RTC_MV_LO         16'h07D0
`define RTC_MV_HI         16'h0E42
`define RTC_AMP_LO        16'hEC78
`define RTC_AMP_HI        16'h1388
`define RTC_SOC_LO        16'h0001
`define RTC_SOC_HI        16'h0063

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTC_CLK_MHZ       50
`define RTC_TICK_MS       1

`endif

// [rtl/rtc_pkg.sv]
`default_nettype none
package rtc_pkg;
   typedef enum logic [2:0] {
      RTC_PROF_OFF  = 3'h0,
      RTC_PROF_VMIN = 3'h1,
      RTC_PROF_VAVG = 3'h2,
      RTC_PROF_VMAX = 3'h3,
      RTC_PROF_CURR = 3'h4,
      RTC_PROF_SOC  = 3'h5,
      RTC_PROF_ALM  = 3'h6,
      RTC_PROF_GEN  = 3'h7
   } rtc_prof_t;
   typedef enum logic [1:0] {
      RTC_OP_AUTO = 2'h0,
      RTC_OP_ON   = 2'h1,
      RTC_OP_OFF  = 2'h2
   } rtc_op_t;
   typedef enum logic [1:0] {
      RTC_ST_IDLE   = 2'h0,
      RTC_ST_ARM    = 2'h1,
      RTC_ST_ON     = 2'h3,
      RTC_ST_DISARM = 2'h2
   } rtc_st_t;
   typedef enum logic [1:0] {
      RTC_LVL_WARN  = 2'h0,
      RTC_LVL_PRE   = 2'h1,
      RTC_LVL_FAULT = 2'h2
   } rtc_lvl_t;
endpackage : rtc_pkg
`default_nettype wire

// [rtl/rtc_top.sv]
// Implementation choices: the register addresses and register access over Avalon-MM.
`include "rtc_map.svh"
`default_nettype none
module rtc_top
   import rtc_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `RTC_TICK_MS * 1000 * `RTC_CLK_MHZ,
   parameter int unsigned DLY_W       = 24,
   parameter int unsigned NUM_ALM     = 10
) (
   input  wire logic                clk_in,
   input  wire logic                nrst_in,
   input  wire logic [7:0]          avs_address_in,
   input  wire logic                avs_read_in,
   input  wire logic                avs_write_in,
   input  wire logic [31:0]         avs_writedata_in,
   input  wire logic [3:0]          avs_byteenable_in,
   output logic      [31:0]         avs_readdata_out,
   output logic                     avs_waitrequest_out,
   input  wire logic [15:0]         cell_min_mv_in,
   input  wire logic [15:0]         cell_avg_mv_in,
   input  wire logic [15:0]         cell_max_mv_in,
   input  wire logic signed [15:0]  current_a_in,
   input  wire logic [7:0]          soc_pct_in,
   input  wire logic [NUM_ALM-1:0]  alarm_warn_in,
   input  wire logic [NUM_ALM-1:0]  alarm_prefault_in,
   input  wire logic [NUM_ALM-1:0]  alarm_fault_in,
   input  wire logic                quiet_window_in,
   input  wire logic                exercise_window_in,
   input  wire logic [1:0]          nv_opstate_in,
   output logic      [1:0]          nv_opstate_out,
   output logic                     relay_out
);

   // -------------------------------------------------------------------------
   // Reset synchroniser
   // -------------------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // -------------------------------------------------------------------------
   // Millisecond tick
   // -------------------------------------------------------------------------
   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
   logic [TICK_W-1:0] tick_cnt_r;
   logic              tick;

   assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      end
   end

   // -------------------------------------------------------------------------
   // Register storage
   // -------------------------------------------------------------------------
   rtc_prof_t            prof_r;
   rtc_op_t              op_r;
   rtc_st_t              st_r;
   rtc_st_t              st_nxt;
   logic                 dir_r;
   logic                 comb_r;
   logic signed [15:0]   act_thr_r;
   logic signed [15:0]   deact_thr_r;
   logic [DLY_W-1:0]     act_dly_r;
   logic [DLY_W-1:0]     deact_dly_r;
   logic [DLY_W-1:0]     max_run_r;
   logic [NUM_ALM-1:0]   alm_en_r;
   logic [2*NUM_ALM-1:0] alm_lvl_r;
   logic                 quiet_en_r;
   logic                 exer_en_r;
   logic                 err_r;
   logic                 loaded_r;
   logic                 act_cond;
   logic                 deact_cond;

   logic        wr_acc;
   logic        rd_first;
   logic [31:0] wd;
   logic [31:0] old_word;
   logic [31:0] rd_nxt;
   logic        thr_bad;

   function automatic logic [31:0] rtc_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction : rtc_merge

   // Thresholds out of range for the current profile are refused; the reset value and later profile changes are not checked.
   function automatic logic rtc_thr_ok(input rtc_prof_t p, input logic signed [15:0] v);
      logic ok;
      ok = 1'b1;
      case (p)
         RTC_PROF_VMIN, RTC_PROF_VAVG, RTC_PROF_VMAX: begin
            ok = (v >= $signed(`RTC_MV_LO)) && (v <= $signed(`RTC_MV_HI));
         end
         RTC_PROF_CURR: begin
            ok = (v >= $signed(`RTC_AMP_LO)) && (v <= $signed(`RTC_AMP_HI));
         end
         RTC_PROF_SOC, RTC_PROF_GEN: begin
            ok = (v >= $signed(`RTC_SOC_LO)) && (v <= $signed(`RTC_SOC_HI));
         end
         default: begin
            ok = 1'b1;
         end
      endcase
      return ok;
   endfunction : rtc_thr_ok

   // -------------------------------------------------------------------------
   // Avalon slave handshake
   // -------------------------------------------------------------------------
   // One wait state: the first request cycle latches read data, the second
   // cycle lowers waitrequest, so read data is stable when the master samples.
   assign wr_acc   = avs_write_in & ~avs_waitrequest_out;
   assign rd_first = avs_read_in & avs_waitrequest_out;

   always_comb begin
      old_word = 32'h0000_0000;
      case (avs_address_in)
         `RTC_OFS_ACT_THR:   old_word = {16'h0000, act_thr_r};
         `RTC_OFS_DEACT_THR: old_word = {16'h0000, deact_thr_r};
         default:            old_word = 32'h0000_0000;
      endcase
      wd = rtc_merge(old_word, avs_writedata_in, avs_byteenable_in);
      thr_bad = wr_acc && !rtc_thr_ok(prof_r, wd[15:0])
                && ((avs_address_in == `RTC_OFS_ACT_THR)
                 || (avs_address_in == `RTC_OFS_DEACT_THR));
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (avs_address_in)
         `RTC_OFS_CTRL: begin
            rd_nxt[`RTC_CTRL_PROF_LSB +: 3] = prof_r;
            rd_nxt[`RTC_CTRL_DIR_BIT]       = dir_r;
            rd_nxt[`RTC_CTRL_COMB_BIT]      = comb_r;
            rd_nxt[`RTC_CTRL_OP_LSB +: 2]   = op_r;
         end
         `RTC_OFS_ACT_THR:   rd_nxt = {{16{act_thr_r[15]}}, act_thr_r};
         `RTC_OFS_DEACT_THR: rd_nxt = {{16{deact_thr_r[15]}}, deact_thr_r};
         `RTC_OFS_ACT_DLY:   rd_nxt[DLY_W-1:0] = act_dly_r;
         `RTC_OFS_DEACT_DLY: rd_nxt[DLY_W-1:0] = deact_dly_r;
         `RTC_OFS_MAX_RUN:   rd_nxt[DLY_W-1:0] = max_run_r;
         `RTC_OFS_ALM_EN:    rd_nxt[NUM_ALM-1:0] = alm_en_r;
         `RTC_OFS_ALM_LVL:   rd_nxt[2*NUM_ALM-1:0] = alm_lvl_r;
         `RTC_OFS_SCHED: begin
            rd_nxt[`RTC_SCHED_QUIET] = quiet_en_r;
            rd_nxt[`RTC_SCHED_EXER]  = exer_en_r;
         end
         `RTC_OFS_STATUS: begin
            rd_nxt[`RTC_STAT_RELAY]         = relay_out;
            rd_nxt[`RTC_STAT_FSM_LSB +: 2]  = st_r;
            rd_nxt[`RTC_STAT_ERR]           = err_r;
            rd_nxt[`RTC_STAT_ACT]           = act_cond;
            rd_nxt[`RTC_STAT_DEACT]         = deact_cond;
            rd_nxt[`RTC_STAT_OP_LSB +: 2]   = op_r;
         end
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (rd_first) begin
         avs_readdata_out <= rd_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prof_r      <= RTC_PROF_OFF;
         dir_r       <= 1'b0;
         comb_r      <= 1'b0;
         act_thr_r   <= `RTC_RST_THR;
         deact_thr_r <= `RTC_RST_THR;
         act_dly_r   <= DLY_W'(`RTC_RST_DLY);
         deact_dly_r <= DLY_W'(`RTC_RST_DLY);
         max_run_r   <= DLY_W'(`RTC_RST_DLY);
         alm_en_r    <= NUM_ALM'(`RTC_RST_ALM);
         alm_lvl_r   <= (2*NUM_ALM)'(`RTC_RST_ALM);
         quiet_en_r  <= 1'b0;
         exer_en_r   <= 1'b0;
      end else if (wr_acc) begin
         case (avs_address_in)
            `RTC_OFS_CTRL: begin
               if (avs_byteenable_in[0]) begin
                  prof_r <= rtc_prof_t'(avs_writedata_in[`RTC_CTRL_PROF_LSB +: 3]);
                  dir_r  <= avs_writedata_in[`RTC_CTRL_DIR_BIT];
                  comb_r <= avs_writedata_in[`RTC_CTRL_COMB_BIT];
               end
            end
            `RTC_OFS_ACT_THR: begin
               if (!thr_bad) begin
                  act_thr_r <= wd[15:0];
               end
            end
            `RTC_OFS_DEACT_THR: begin
               if (!thr_bad) begin
                  deact_thr_r <= wd[15:0];
               end
            end
            `RTC_OFS_ACT_DLY: begin
               act_dly_r <= DLY_W'(rtc_merge(32'(act_dly_r), avs_writedata_in,
                                             avs_byteenable_in));
            end
            `RTC_OFS_DEACT_DLY: begin
               deact_dly_r <= DLY_W'(rtc_merge(32'(deact_dly_r), avs_writedata_in,
                                               avs_byteenable_in));
            end
            `RTC_OFS_MAX_RUN: begin
               max_run_r <= DLY_W'(rtc_merge(32'(max_run_r), avs_writedata_in,
                                             avs_byteenable_in));
            end
            `RTC_OFS_ALM_EN: begin
               alm_en_r <= NUM_ALM'(rtc_merge(32'(alm_en_r), avs_writedata_in,
                                              avs_byteenable_in));
            end
            `RTC_OFS_ALM_LVL: begin
               alm_lvl_r <= (2*NUM_ALM)'(rtc_merge(32'(alm_lvl_r), avs_writedata_in,
                                                   avs_byteenable_in));
            end
            `RTC_OFS_SCHED: begin
               if (avs_byteenable_in[0]) begin
                  quiet_en_r <= avs_writedata_in[`RTC_SCHED_QUIET];
                  exer_en_r  <= avs_writedata_in[`RTC_SCHED_EXER];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Sticky range error; a new refusal in the clearing cycle keeps it set.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else if (thr_bad) begin
         err_r <= 1'b1;
      end else if (wr_acc && (avs_address_in == `RTC_OFS_STATUS)
                   && avs_byteenable_in[0] && avs_writedata_in[`RTC_STAT_ERR]) begin
         err_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Operating state with retention
   // -------------------------------------------------------------------------
   // The retained copy is taken once, in the first cycle after reset release,
   // and mirrored out one clock later, so the outside store holds the current choice.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         op_r     <= RTC_OP_AUTO;
         loaded_r <= 1'b0;
      end else if (!loaded_r) begin
         loaded_r <= 1'b1;
         if (nv_opstate_in != 2'h3) begin
            op_r <= rtc_op_t'(nv_opstate_in);
         end
      end else if (wr_acc && (avs_address_in == `RTC_OFS_CTRL) && avs_byteenable_in[1]
                   && (avs_writedata_in[`RTC_CTRL_OP_LSB +: 2] != 2'h3)) begin
         op_r <= rtc_op_t'(avs_writedata_in[`RTC_CTRL_OP_LSB +: 2]);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         nv_opstate_out <= 2'h0;
      end else begin
         nv_opstate_out <= op_r;
      end
   end

   // -------------------------------------------------------------------------
   // Trigger source and comparison
   // -------------------------------------------------------------------------
   logic signed [17:0]  src;
   logic signed [17:0]  act_x;
   logic signed [17:0]  deact_x;
   logic [NUM_ALM-1:0]  alm_hit;
   logic                alm_cond;
   logic                num_act;
   logic                num_deact;
   logic                gen;
   logic                quiet;
   logic                exer;

   always_comb begin
      case (prof_r)
         RTC_PROF_VMIN: src = {2'h0, cell_min_mv_in};
         RTC_PROF_VAVG: src = {2'h0, cell_avg_mv_in};
         RTC_PROF_VMAX: src = {2'h0, cell_max_mv_in};
         RTC_PROF_CURR: src = 18'(current_a_in);
         RTC_PROF_SOC:  src = {10'h000, soc_pct_in};
         RTC_PROF_GEN:  src = {10'h000, soc_pct_in};
         default:       src = 18'h00000;
      endcase
   end

   assign act_x   = 18'(act_thr_r);
   assign deact_x = 18'(deact_thr_r);

   // Deactivation uses the opposite sense so the two thresholds form a band.
   assign num_act   = dir_r ? (src > act_x) : (src < act_x);
   assign num_deact = dir_r ? (src < deact_x) : (src > deact_x);

   always_comb begin
      alm_hit = '0;
      for (int i = 0; i < NUM_ALM; i++) begin
         case (rtc_lvl_t'(alm_lvl_r[2*i +: 2]))
            RTC_LVL_WARN:  alm_hit[i] = alarm_warn_in[i];
            RTC_LVL_PRE:   alm_hit[i] = alarm_prefault_in[i];
            RTC_LVL_FAULT: alm_hit[i] = alarm_fault_in[i];
            default:       alm_hit[i] = alarm_fault_in[i];
         endcase
      end
      alm_hit = alm_hit & alm_en_r;
      alm_cond = comb_r ? ((alm_en_r != '0) && (alm_hit == alm_en_r))
                        : (alm_hit != '0);
   end

   assign act_cond   = (prof_r == RTC_PROF_ALM) ? alm_cond : num_act;
   assign deact_cond = (prof_r == RTC_PROF_ALM) ? ~alm_cond : num_deact;

   assign gen   = (prof_r == RTC_PROF_GEN);
   assign quiet = gen & quiet_en_r & quiet_window_in;
   assign exer  = gen & exer_en_r & exercise_window_in;

   // -------------------------------------------------------------------------
   // Automatic sequencer
   // -------------------------------------------------------------------------
   logic [DLY_W-1:0] dly_cnt_r;
   logic [DLY_W-1:0] run_cnt_r;
   logic             run_exp;
   logic             on_st;

   assign on_st   = (st_r == RTC_ST_ON) || (st_r == RTC_ST_DISARM);
   assign run_exp = gen && (max_run_r != '0) && (run_cnt_r >= max_run_r);

   always_comb begin
      st_nxt = st_r;
      if ((prof_r == RTC_PROF_OFF) || (op_r != RTC_OP_AUTO) || exer) begin
         st_nxt = RTC_ST_IDLE;
      end else begin
         case (st_r)
            RTC_ST_IDLE: begin
               if (act_cond && !quiet) st_nxt = RTC_ST_ARM;
            end
            RTC_ST_ARM: begin
               if (!act_cond || quiet) st_nxt = RTC_ST_IDLE;
               else if (dly_cnt_r >= act_dly_r) st_nxt = RTC_ST_ON;
            end
            RTC_ST_ON: begin
               if (run_exp) st_nxt = RTC_ST_IDLE;
               else if (deact_cond) st_nxt = RTC_ST_DISARM;
            end
            RTC_ST_DISARM: begin
               if (run_exp) st_nxt = RTC_ST_IDLE;
               else if (!deact_cond) st_nxt = RTC_ST_ON;
               else if (dly_cnt_r >= deact_dly_r) st_nxt = RTC_ST_IDLE;
            end
            default: st_nxt = RTC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= RTC_ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Delays count whole ticks, so a delay of N ends after N-1 to N ticks.
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         dly_cnt_r <= '0;
      end else if (st_nxt != st_r) begin
         dly_cnt_r <= '0;
      end else if (tick && (dly_cnt_r != '1)) begin
         dly_cnt_r <= dly_cnt_r + DLY_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         run_cnt_r <= '0;
      end else if (!on_st || (st_nxt == RTC_ST_IDLE)) begin
         run_cnt_r <= '0;
      end else if (tick && (run_cnt_r != '1)) begin
         run_cnt_r <= run_cnt_r + DLY_W'(1);
      end
   end

   // -------------------------------------------------------------------------
   // Relay drive
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         relay_out <= 1'b0;
      end else if (op_r == RTC_OP_ON) begin
         relay_out <= 1'b1;
      end else if (op_r == RTC_OP_OFF) begin
         relay_out <= 1'b0;
      end else if (prof_r == RTC_PROF_OFF) begin
         relay_out <= 1'b0;
      end else if (exer) begin
         relay_out <= 1'b1;
      end else begin
         relay_out <= (st_nxt == RTC_ST_ON) || (st_nxt == RTC_ST_DISARM);
      end
   end

endmodule : rtc_top
`default_nettype wire

// [sim/rtc_bms_model.sv]
`default_nettype none
module rtc_bms_model (
   input  wire logic        clk_in,
   output logic      [15:0] mv_out,
   output logic      [7:0]  soc_out,
   output logic      [9:0]  warn_out,
   output logic      [9:0]  flt_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------------------------------------------------------------
   // Telemetry frames
   // ------------------------------------------------------------
   // A frame lands whole just after an edge, so no half frame is seen.
   initial begin
      mv_out = 16'h0C1C;
      soc_out = 8'h32;
      warn_out = 10'h000;
      flt_out = 10'h000;
   end
   task automatic set(input logic [15:0] mv, input logic [7:0] s,
                      input logic [9:0] w, input logic [9:0] f);
      @(posedge clk_in);
      mv_out <= mv;
      soc_out <= s;
      warn_out <= w;
      flt_out <= f;
   endtask : set
endmodule : rtc_bms_model
`default_nettype wire

// [sim/rtc_top_checker.sv]
`default_nettype none
module rtc_top_checker (
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic [7:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic        avs_waitrequest_out,
   input wire logic [1:0]  nv_opstate_out,
   input wire logic        relay_out
);
   // ------------------------------------------------------------
   // Bus and relay properties
   // ------------------------------------------------------------
   // The design's flops only take reset at the first edge, so that edge is skipped.
   logic seen_r = 1'b0;
   always_ff @(posedge clk_in) seen_r <= 1'b1;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_ack_next: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("no ack");
   a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("long ack");
   a_ack_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
      else $error("stray ack");
   a_on_holds: assert property (nv_opstate_out == 2'h1 && $stable(nv_opstate_out)
      |-> relay_out) else $error("forced on low");
   a_off_holds: assert property (nv_opstate_out == 2'h2 && $stable(nv_opstate_out)
      |-> !relay_out) else $error("forced off high");
   a_op_legal: assert property (nv_opstate_out != 2'h3) else $error("bad op");
   a_op_write: assert property (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[1]
      && avs_address_in == 8'h00 && avs_writedata_in[9:8] != 2'h3
      |-> ##2 nv_opstate_out == $past(avs_writedata_in[9:8], 2)) else $error("op lost");
   a_rst_idle: assert property (disable iff (1'b0) seen_r && !nrst_in
      |-> !relay_out && nv_opstate_out == 2'h0 && avs_waitrequest_out) else $error("reset");
endmodule : rtc_top_checker
bind rtc_top rtc_top_checker i_chk (.*);
`default_nettype wire

// [sim/test_rtc_top.sv]
`default_nettype none
module test_rtc_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0, nrst_in = 1'b0, ren = 1'b0, wen = 1'b0;
   logic        quiet = 1'b0, exer = 1'b0, avs_waitrequest_out, relay_out;
   logic [1:0]  nv = 2'h1, nv_opstate_out;
   logic [3:0]  be = 4'hF;
   logic [7:0]  adr = 8'h00, soc;
   logic [9:0]  warn, flt;
   logic [15:0] mv;
   logic [31:0] wdat = 32'h0, rdat, avs_readdata_out;
   int          miscompares = 0, samples_checked = 0;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   initial forever #10 clk_in = ~clk_in;
   rtc_bms_model i_bms (.clk_in(clk_in), .mv_out(mv), .soc_out(soc), .warn_out(warn),
      .flt_out(flt));
   // A four-clock tick keeps every delay short; waits below scale with it.
   rtc_top #(.TICK_CYCLES(4)) i_dut (.*, .avs_address_in(adr), .avs_read_in(ren),
      .avs_write_in(wen), .avs_writedata_in(wdat), .avs_byteenable_in(be),
      .cell_min_mv_in(mv), .cell_avg_mv_in(mv), .cell_max_mv_in(mv),
      .current_a_in(16'sh0000), .soc_pct_in(soc), .alarm_warn_in(warn),
      .alarm_prefault_in(10'h000), .alarm_fault_in(flt), .quiet_window_in(quiet),
      .exercise_window_in(exer), .nv_opstate_in(nv));
   task automatic end_sim;
      $display("checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk_in);
      adr <= a;
      wdat <= d;
      be <= b;
      wen <= w;
      ren <= !w;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 40);
      rdat = avs_readdata_out;
      wen <= 1'b0;
      ren <= 1'b0;
      if (n >= 40) begin
         miscompares++;
         $display("unexpected at %0t: bus timeout", $time);
         end_sim();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hF);
      cmp(rdat, e);
   endtask : rd
   task automatic wrel(input logic e, input int m);
      int n;
      n = 0;
      while (relay_out !== e && n < m) begin
         @(posedge clk_in);
         n++;
      end
      cmp({31'h0, relay_out}, {31'h0, e});
   endtask : wrel
   initial begin
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      wrel(1'b1, 8);
      rd(8'h3C, 32'h0);
      bus(1'b1, 8'h00, 32'h200, 4'h2);
      wrel(1'b0, 4);
      bus(1'b1, 8'h00, 32'h300, 4'h2);
      rd(8'h00, 32'h200);
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h7CF);
      rd(8'h04, 32'h0);
      wr(8'h04, 32'hBB8);
      wr(8'h08, 32'hC80);
      wr(8'h0C, 32'h2);
      wr(8'h10, 32'h2);
      i_bms.set(16'h0B54, 8'h0A, 10'h000, 10'h000);
      repeat (4) @(posedge clk_in);
      i_bms.set(16'h0C1C, 8'h0A, 10'h000, 10'h000);
      repeat (20) @(posedge clk_in);
      wrel(1'b0, 0);
      i_bms.set(16'h0B54, 8'h0A, 10'h000, 10'h000);
      repeat (6) @(posedge clk_in);
      wrel(1'b0, 0);
      wrel(1'b1, 20);
      i_bms.set(16'h0CE4, 8'h0A, 10'h000, 10'h000);
      repeat (6) @(posedge clk_in);
      wrel(1'b1, 0);
      wrel(1'b0, 20);
      wr(8'h00, 32'h11);
      wrel(1'b1, 30);
      i_bms.set(16'h0B54, 8'h0A, 10'h000, 10'h000);
      wrel(1'b0, 30);
      wr(8'h00, 32'h26);
      wr(8'h18, 32'h3);
      wr(8'h1C, 32'h8);
      i_bms.set(16'h0B54, 8'h0A, 10'h003, 10'h000);
      repeat (20) @(posedge clk_in);
      wrel(1'b0, 0);
      i_bms.set(16'h0B54, 8'h0A, 10'h003, 10'h002);
      wrel(1'b1, 30);
      i_bms.set(16'h0B54, 8'h0A, 10'h000, 10'h000);
      wrel(1'b0, 30);
      quiet <= 1'b1;
      wr(8'h20, 32'h3);
      wr(8'h00, 32'h7);
      wr(8'h04, 32'h14);
      wr(8'h08, 32'h50);
      wr(8'h04, 32'h64);
      rd(8'h04, 32'h14);
      rd(8'h24, 32'h18);
      wr(8'h24, 32'h8);
      rd(8'h24, 32'h10);
      repeat (30) @(posedge clk_in);
      wrel(1'b0, 0);
      exer <= 1'b1;
      wrel(1'b1, 10);
      bus(1'b1, 8'h00, 32'h200, 4'h2);
      wrel(1'b0, 4);
      bus(1'b1, 8'h00, 32'h0, 4'h2);
      exer <= 1'b0;
      quiet <= 1'b0;
      wrel(1'b1, 40);
      wr(8'h14, 32'h2);
      wrel(1'b0, 40);
      wrel(1'b1, 40);
      end_sim();
   end
endmodule : test_rtc_top
`default_nettype wire
